// File: rtl/ipru_regs.sv
// Upper interrupt priority register bank with per-source priority outputs
//
// Notes on behaviour
// [R01] Code 111 means level 7, highest
// [R02] Code 001 is level 1; linear between
// [R03] Code 000 disables the source entirely
// [R04] Non-field bits always read zero
// [R05] Fields reset to 100, stay read/write
// [R06] 64-pin variant drops parallel port field
// [R07] Reg 11: parallel port 6-4, OC8 2-0
// [R08] Reg 12: I2C2 master 10-8, slave 6-4
// [R09] Reg 13: ext irq4 10-8, irq3 6-4
// [R10] Reg 15: clock calendar in 10-8 only
// [R11] Reg 16: CRC 14-12, UART2/1 errors
// [R12] Reg 18: low voltage in 2-0 only
// [R13] Reg 19: charge time in 6-4 only
// [R14] Reg 20: UART3 tx, rx, error
// [R15] Reg 21: UART4 err, USB, I2C3 pair
// [R16] Reg 22: SPI3 event in 14-12
// [R17] Reg 22: SPI3 fault, UART4 tx/rx
// [R18] Every source starts at level 4
// [R19] Fields drive arbitration, next cycle effect
// [R20] Writes to unimplemented bits ignored
`timescale 1ns/1ps
`include "ipru_params.svh"

module ipru_regs #(
    parameter bit PINS_64 = 1'b0
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic reset_in,
    // Register port
    input wire logic [3:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [15:0] rdata_out,
    // Priorities to the arbiter
    output ipru_pkg::ipru_prio_bank_t prio_out,
    output ipru_pkg::ipru_src_vec_t src_active_out
);
    import ipru_pkg::*;

    localparam int NREG = `IPRU_NUM_REGS;

    // Implemented-bit mask per register index
    function automatic logic [15:0] reg_mask(input logic [3:0] idx);
        logic [15:0] m;
        m = 16'h0000;
        case (idx)
            // [R07] [R06] pmp field gone on 64-pin
            `IPRU_OFF_PMP_OC8: m = PINS_64 ? `IPRU_MASK_PMP_OC8_64 : `IPRU_MASK_PMP_OC8;
            // [R08] i2c2 layout
            `IPRU_OFF_I2C2: m = `IPRU_MASK_I2C2;
            // [R09] external irq layout
            `IPRU_OFF_EXT_IRQ: m = `IPRU_MASK_EXT_IRQ;
            // [R10] calendar only
            `IPRU_OFF_RTC: m = `IPRU_MASK_RTC;
            // [R11] crc and uart errors
            `IPRU_OFF_CRC_UART: m = `IPRU_MASK_CRC_UART;
            // [R12] low voltage only
            `IPRU_OFF_LOW_VOLT: m = `IPRU_MASK_LOW_VOLT;
            // [R13] charge time only
            `IPRU_OFF_CHARGE: m = `IPRU_MASK_CHARGE;
            // [R14] uart3 fields
            `IPRU_OFF_UART3: m = `IPRU_MASK_UART3;
            // [R15] four fields
            `IPRU_OFF_U4_USB_I2C3: m = `IPRU_MASK_U4_USB_I2C3;
            // [R16] [R17] spi3 and uart4
            `IPRU_OFF_SPI3_U4: m = `IPRU_MASK_SPI3_U4;
            default: m = 16'h0000;
        endcase
        return m;
    endfunction

    logic [15:0] regs [NREG];
    logic [15:0] next_regs [NREG];
    logic [15:0] rdata;
    logic [15:0] next_rdata;
    ipru_prio_bank_t prio;
    ipru_prio_bank_t next_prio;
    ipru_src_vec_t src_active;
    ipru_src_vec_t next_src_active;

    // Register writes
    generate
        for (genvar i = 0; i < NREG; i++) begin : g_reg
            always_comb begin
                next_regs[i] = regs[i];
                if (wr_in && addr_in == 4'(i)) begin
                    // [R20] masked write
                    next_regs[i] = wdata_in & reg_mask(4'(i));
                end
            end

            always_ff @(posedge mclk_in) begin
                if (reset_in) begin
                    // [R05] [R18] reset to level 4
                    regs[i] <= `IPRU_RESET_ALL & reg_mask(4'(i));
                end else begin
                    regs[i] <= next_regs[i];
                end
            end
        end
    endgenerate

    // Read data, one cycle after the strobe; unmapped reads zero
    always_comb begin
        next_rdata = 16'h0000;
        if (rd_in && addr_in < 4'(NREG)) begin
            // [R04] unimplemented bits zero
            next_rdata = regs[addr_in] & reg_mask(addr_in);
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            rdata <= 16'h0000;
        end else begin
            rdata <= next_rdata;
        end
    end

    // Field extraction for the arbiter; uses next values so outputs follow regs
    always_comb begin
        // [R19] fields feed arbitration
        next_prio.parallel_port_prio = next_regs[`IPRU_OFF_PMP_OC8][`IPRU_POS_ML +: 3];
        next_prio.out_compare8_prio = next_regs[`IPRU_OFF_PMP_OC8][`IPRU_POS_LO +: 3];
        next_prio.i2c2_master_prio = next_regs[`IPRU_OFF_I2C2][`IPRU_POS_MH +: 3];
        next_prio.i2c2_slave_prio = next_regs[`IPRU_OFF_I2C2][`IPRU_POS_ML +: 3];
        next_prio.ext_irq4_prio = next_regs[`IPRU_OFF_EXT_IRQ][`IPRU_POS_MH +: 3];
        next_prio.ext_irq3_prio = next_regs[`IPRU_OFF_EXT_IRQ][`IPRU_POS_ML +: 3];
        next_prio.clock_calendar_prio = next_regs[`IPRU_OFF_RTC][`IPRU_POS_MH +: 3];
        next_prio.crc_error_prio = next_regs[`IPRU_OFF_CRC_UART][`IPRU_POS_HI +: 3];
        next_prio.uart2_error_prio = next_regs[`IPRU_OFF_CRC_UART][`IPRU_POS_MH +: 3];
        next_prio.uart1_error_prio = next_regs[`IPRU_OFF_CRC_UART][`IPRU_POS_ML +: 3];
        next_prio.low_voltage_prio = next_regs[`IPRU_OFF_LOW_VOLT][`IPRU_POS_LO +: 3];
        next_prio.charge_time_prio = next_regs[`IPRU_OFF_CHARGE][`IPRU_POS_ML +: 3];
        next_prio.uart3_tx_prio = next_regs[`IPRU_OFF_UART3][`IPRU_POS_HI +: 3];
        next_prio.uart3_rx_prio = next_regs[`IPRU_OFF_UART3][`IPRU_POS_MH +: 3];
        next_prio.uart3_error_prio = next_regs[`IPRU_OFF_UART3][`IPRU_POS_ML +: 3];
        next_prio.uart4_error_prio = next_regs[`IPRU_OFF_U4_USB_I2C3][`IPRU_POS_HI +: 3];
        next_prio.usb_otg_prio = next_regs[`IPRU_OFF_U4_USB_I2C3][`IPRU_POS_MH +: 3];
        next_prio.i2c3_master_prio = next_regs[`IPRU_OFF_U4_USB_I2C3][`IPRU_POS_ML +: 3];
        next_prio.i2c3_slave_prio = next_regs[`IPRU_OFF_U4_USB_I2C3][`IPRU_POS_LO +: 3];
        next_prio.spi3_event_prio = next_regs[`IPRU_OFF_SPI3_U4][`IPRU_POS_HI +: 3];
        next_prio.spi3_fault_prio = next_regs[`IPRU_OFF_SPI3_U4][`IPRU_POS_MH +: 3];
        next_prio.uart4_tx_prio = next_regs[`IPRU_OFF_SPI3_U4][`IPRU_POS_ML +: 3];
        next_prio.uart4_rx_prio = next_regs[`IPRU_OFF_SPI3_U4][`IPRU_POS_LO +: 3];
    end

    // A source with code 000 is withheld from arbitration
    generate
        for (genvar s = 0; s < 23; s++) begin : g_src
            always_comb begin
                // [R03] zero code disables
                next_src_active[s] = |next_prio[s*3 +: 3];
            end
        end
    endgenerate

    // Priorities are registered so the outputs come straight from flops and
    // match the register contents in the same cycle
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            // [R01] [R02] code is the level itself
            prio <= {23{`IPRU_PRIO_RESET}} & {23{3'h7}} & (PINS_64 ?
                    {3'h0, {22{`IPRU_PRIO_RESET}}} : {23{`IPRU_PRIO_RESET}});
            src_active <= PINS_64 ? {1'b0, {22{1'b1}}} : {23{1'b1}};
        end else begin
            prio <= next_prio;
            src_active <= next_src_active;
        end
    end

    assign rdata_out = rdata;
    assign prio_out = prio;
    assign src_active_out = src_active;

    // Assertions
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (reset_in);

    read_zero_bits_a: assert property ( // [R04]
        rd_in |=> (rdata_out & ~reg_mask($past(addr_in))) == 16'h0000)
        else $error("unimplemented bits read nonzero");
    write_mask_a: assert property ( // [R20]
        wr_in && addr_in == `IPRU_OFF_RTC |=> regs[`IPRU_OFF_RTC] == ($past(wdata_in) & 16'h0700))
        else $error("write changed unimplemented bits");
    write_effect_a: assert property ( // [R19]
        wr_in && addr_in == `IPRU_OFF_SPI3_U4 |=>
            prio_out.spi3_event_prio == $past(wdata_in[14:12]))
        else $error("priority not updated next cycle");
    disable_zero_a: assert property ( // [R03]
        src_active_out[0] == (prio_out.uart4_rx_prio != 3'h0))
        else $error("disabled source still active");
    reg_readback_a: assert property ( // [R05]
        wr_in && addr_in == `IPRU_OFF_UART3 ##1 rd_in && addr_in == `IPRU_OFF_UART3
            |=> rdata_out == ($past(wdata_in, 2) & 16'h7770))
        else $error("readback mismatch");
    reset_level_a: assert property (@(posedge mclk_in) disable iff (1'b0) // [R18]
        $past(reset_in) |-> prio_out.usb_otg_prio == 3'h4 && regs[`IPRU_OFF_LOW_VOLT] == 16'h0004)
        else $error("reset level not four");
    pins64_field_a: assert property ( // [R06]
        PINS_64 |-> prio_out.parallel_port_prio == 3'h0)
        else $error("parallel port field present on 64-pin");
    field_layout_a: assert property ( // [R15]
        prio_out.i2c3_slave_prio == regs[`IPRU_OFF_U4_USB_I2C3][2:0])
        else $error("i2c3 slave field misplaced");
    oc8_layout_a: assert property ( // [R07]
        prio_out.out_compare8_prio == regs[`IPRU_OFF_PMP_OC8][2:0])
        else $error("compare 8 field misplaced");
    i2c2_layout_a: assert property ( // [R08]
        prio_out.i2c2_master_prio == regs[`IPRU_OFF_I2C2][10:8])
        else $error("i2c2 master field misplaced");
    ext_irq_layout_a: assert property ( // [R09]
        prio_out.ext_irq3_prio == regs[`IPRU_OFF_EXT_IRQ][6:4])
        else $error("external irq3 field misplaced");
    calendar_layout_a: assert property ( // [R10]
        prio_out.clock_calendar_prio == regs[`IPRU_OFF_RTC][10:8])
        else $error("calendar field misplaced");
    crc_layout_a: assert property ( // [R11]
        prio_out.crc_error_prio == regs[`IPRU_OFF_CRC_UART][14:12])
        else $error("crc field misplaced");
    low_volt_layout_a: assert property ( // [R12]
        prio_out.low_voltage_prio == regs[`IPRU_OFF_LOW_VOLT][2:0])
        else $error("low voltage field misplaced");
    charge_layout_a: assert property ( // [R13]
        prio_out.charge_time_prio == regs[`IPRU_OFF_CHARGE][6:4])
        else $error("charge time field misplaced");
    uart3_layout_a: assert property ( // [R14]
        prio_out.uart3_tx_prio == regs[`IPRU_OFF_UART3][14:12])
        else $error("uart3 tx field misplaced");
    spi3_fault_layout_a: assert property ( // [R17]
        prio_out.spi3_fault_prio == regs[`IPRU_OFF_SPI3_U4][10:8])
        else $error("spi3 fault field misplaced");
    top_code_active_a: assert property ( // [R01]
        prio_out.uart4_rx_prio == 3'h7 |-> src_active_out[0])
        else $error("level seven source not active");
    unmapped_read_a: assert property ( // [R04]
        rd_in && addr_in >= 4'(NREG) |=> rdata_out == 16'h0000)
        else $error("unmapped read nonzero");

    write_then_read_c: cover property (wr_in ##1 rd_in);
    disable_src_c: cover property (wr_in && wdata_in == 16'h0000 ##1 !src_active_out[0]);
    top_level_c: cover property (prio_out.crc_error_prio == 3'h7);
    lowest_level_c: cover property (prio_out.uart1_error_prio == 3'h1);
endmodule

// File: rtl/ipru_params.svh
// Offsets, field positions, reset values and masks of the upper priority registers
`ifndef IPRU_PARAMS_SVH
`define IPRU_PARAMS_SVH

`define IPRU_ADDR_W 4
// Register indices on the plain register port
`define IPRU_OFF_PMP_OC8 4'h0
`define IPRU_OFF_I2C2 4'h1
`define IPRU_OFF_EXT_IRQ 4'h2
`define IPRU_OFF_RTC 4'h3
`define IPRU_OFF_CRC_UART 4'h4
`define IPRU_OFF_LOW_VOLT 4'h5
`define IPRU_OFF_CHARGE 4'h6
`define IPRU_OFF_UART3 4'h7
`define IPRU_OFF_U4_USB_I2C3 4'h8
`define IPRU_OFF_SPI3_U4 4'h9
`define IPRU_NUM_REGS 10

// Field positions (low bit of each 3-bit field)
`define IPRU_POS_HI 12
`define IPRU_POS_MH 8
`define IPRU_POS_ML 4
`define IPRU_POS_LO 0

// Every field resets to level 4
`define IPRU_PRIO_RESET 3'h4

// Implemented-bit masks per register
`define IPRU_MASK_PMP_OC8 16'h0077
`define IPRU_MASK_PMP_OC8_64 16'h0007
`define IPRU_MASK_I2C2 16'h0770
`define IPRU_MASK_EXT_IRQ 16'h0770
`define IPRU_MASK_RTC 16'h0700
`define IPRU_MASK_CRC_UART 16'h7770
`define IPRU_MASK_LOW_VOLT 16'h0007
`define IPRU_MASK_CHARGE 16'h0070
`define IPRU_MASK_UART3 16'h7770
`define IPRU_MASK_U4_USB_I2C3 16'h7777
`define IPRU_MASK_SPI3_U4 16'h7777

// Reset pattern of all four possible fields; masked per register
`define IPRU_RESET_ALL 16'h4444

`endif

// File: rtl/ipru_pkg.sv
// Types shared by the upper priority register bank
package ipru_pkg;
    typedef logic [2:0] ipru_prio_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } ipru_bus_req_t;

    typedef struct packed {
        ipru_prio_t parallel_port_prio;
        ipru_prio_t out_compare8_prio;
        ipru_prio_t i2c2_master_prio;
        ipru_prio_t i2c2_slave_prio;
        ipru_prio_t ext_irq4_prio;
        ipru_prio_t ext_irq3_prio;
        ipru_prio_t clock_calendar_prio;
        ipru_prio_t crc_error_prio;
        ipru_prio_t uart2_error_prio;
        ipru_prio_t uart1_error_prio;
        ipru_prio_t low_voltage_prio;
        ipru_prio_t charge_time_prio;
        ipru_prio_t uart3_tx_prio;
        ipru_prio_t uart3_rx_prio;
        ipru_prio_t uart3_error_prio;
        ipru_prio_t uart4_error_prio;
        ipru_prio_t usb_otg_prio;
        ipru_prio_t i2c3_master_prio;
        ipru_prio_t i2c3_slave_prio;
        ipru_prio_t spi3_event_prio;
        ipru_prio_t spi3_fault_prio;
        ipru_prio_t uart4_tx_prio;
        ipru_prio_t uart4_rx_prio;
    } ipru_prio_bank_t;

    // 23 sources, one active bit each
    typedef logic [22:0] ipru_src_vec_t;
endpackage

// File: verification/ipru_regs_tb_top.sv
// Self-checking bench for the upper priority register bank
`timescale 1ns/1ps
`include "ipru_params.svh"

module ipru_regs_tb_top;
    import ipru_pkg::*;
    logic mclk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [3:0] addr_in = 4'h0;
    logic [15:0] wdata_in = 16'h0;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [15:0] rdata_out;
    logic [15:0] rdata_64;
    logic [15:0] last_64;
    ipru_prio_bank_t prio_out;
    ipru_prio_bank_t prio_64;
    ipru_src_vec_t src_active_out;
    int num_errors = 0;
    int num_checks = 0;
    logic [15:0] mdl [10];
    logic [15:0] mk [10] = '{`IPRU_MASK_PMP_OC8, `IPRU_MASK_I2C2, `IPRU_MASK_EXT_IRQ,
        `IPRU_MASK_RTC, `IPRU_MASK_CRC_UART, `IPRU_MASK_LOW_VOLT, `IPRU_MASK_CHARGE,
        `IPRU_MASK_UART3, `IPRU_MASK_U4_USB_I2C3, `IPRU_MASK_SPI3_U4};
    // Register index and field position of each source, in output order
    int fr [23] = '{0, 0, 1, 1, 2, 2, 3, 4, 4, 4, 5, 6, 7, 7, 7, 8, 8, 8, 8, 9, 9, 9, 9};
    int fp [23] = '{4, 0, 8, 4, 8, 4, 8, 12, 8, 4, 0, 4, 12, 8, 4, 12, 8, 4, 0, 12, 8, 4, 0};

    always #10 mclk_in = ~mclk_in;

    ipru_regs u_dut (.mclk_in(mclk_in), .reset_in(reset_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .prio_out(prio_out), .src_active_out(src_active_out));
    // Smaller package variant shares every input
    ipru_regs #(.PINS_64(1'b1)) u_dut_64 (.mclk_in(mclk_in), .reset_in(reset_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_64), .prio_out(prio_64), .src_active_out());

    task check(input logic [68:0] seen, input logic [68:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge mclk_in);
        wr_in <= 1'b0;
        if (a < 4'ha) begin
            mdl[a] = d & mk[a];
        end
    endtask

    task rd(input logic [3:0] a);
        @(posedge mclk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        #1;
        last_64 = rdata_64;
        check(rdata_out, (a < 4'ha) ? mdl[a] : 16'h0);
        @(posedge mclk_in);
        #1;
        check(rdata_out, 16'h0);
    endtask

    task check_out;
        logic [68:0] eb;
        ipru_src_vec_t es;
        #1;
        for (int i = 0; i < 23; i++) begin
            eb[68-3*i -: 3] = mdl[fr[i]][fp[i] +: 3];
            es[22-i] = (eb[68-3*i -: 3] != 3'h0);
        end
        check(prio_out, eb);
        check({46'h0, src_active_out}, {46'h0, es});
    endtask

    task do_reset;
        @(posedge mclk_in);
        reset_in <= 1'b1;
        repeat (6) @(posedge mclk_in);
        reset_in <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            mdl[i] = mk[i] & `IPRU_RESET_ALL;
        end
    endtask

    task t_reset_state;
        do_reset();
        check_out();
        for (int a = 0; a < 10; a++) begin
            rd(a[3:0]);
        end
    endtask

    // Codes 7, 0, 1 and a mix, written one every other cycle into every register
    task t_patterns;
        logic [15:0] pats [4] = '{16'hffff, 16'h0000, 16'h1111, 16'h5a5a};
        for (int p = 0; p < 4; p++) begin
            for (int a = 0; a < 10; a++) begin
                wr(a[3:0], pats[p]);
            end
            check_out();
            for (int a = 0; a < 10; a++) begin
                rd(a[3:0]);
            end
        end
    endtask

    // Unmapped indices must neither change state nor return data
    task t_unmapped;
        for (int a = 10; a < 16; a++) begin
            wr(a[3:0], 16'hffff);
        end
        check_out();
        rd(4'ha);
        rd(4'hf);
    endtask

    // Write followed after one idle cycle by a read of the same register
    task t_walk;
        wr(4'h9, 16'h1234);
        check_out();
        wr(4'h3, 16'hffff);
        rd(4'h3);
    endtask

    task t_mid_reset;
        wr(4'h7, 16'h0000);
        do_reset();
        check_out();
    endtask

    task t_pins64;
        wr(4'h0, 16'hffff);
        rd(4'h0);
        check({53'h0, last_64}, 69'h7);
        check({66'h0, prio_64.parallel_port_prio}, 69'h0);
        check({66'h0, prio_64.out_compare8_prio}, 69'h7);
    endtask

    task give_verdict;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        t_reset_state();
        t_patterns();
        t_unmapped();
        t_walk();
        t_mid_reset();
        t_pins64();
        give_verdict();
    end

    // Whole run is well under two thousand cycles
    initial begin
        #200000;
        num_errors++;
        give_verdict();
    end
endmodule
